// >>> logic/pcr_chan_out.sv
/*
  pcr_chan_out: one pwm channel output stage, compare and inversion.
  assumes: counter and active duty come from the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module pcr_chan_out (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [pcr_pkg::CNT_W-1:0] cnt,
  input wire logic [pcr_pkg::CNT_W-1:0] duty,
  input wire logic invert,
  output logic pin
);
  logic raw;
  wire next_raw = run ? (cnt < duty) : raw; // halted generator holds its level

  // generator level and inverted pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw <= 1'b0;
      pin <= 1'b0;
    end else begin
      raw <= next_raw;
      pin <= next_raw ^ invert; // [R7]
    end
  end

  chk_invert_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    ##1 (pin == ($past(next_raw) ^ $past(invert))))
    else $error("pin polarity does not follow invert bit");
endmodule // pcr_chan_out
`default_nettype wire

// >>> logic/pcr_pkg.sv
/*
  pcr_pkg: register indices, field positions, reset values and widths
  for the pwm counter and reload control block.
  assumes: a 32-bit axi4-lite slave, registers one aligned word each.
*/
package pcr_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W = 10;
  localparam int NUM_CH = 4;
  localparam int IDX_W = 8;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PERIOD_LOW = 8'hd9;
  localparam logic [IDX_W-1:0] IDX_CONTROL_ONE = 8'hdc;
  localparam logic [IDX_W-1:0] IDX_DUTY_HIGH = 8'he8;
  localparam logic [IDX_W-1:0] IDX_PERIOD_HIGH = 8'he9;
  // duty low bytes, channel 0 first
  localparam logic [IDX_W-1:0] IDX_DUTY_LOW [NUM_CH] = '{8'hda, 8'hdb, 8'hdd, 8'hde};
  // pwm_control_one field positions
  localparam int BIT_RUN = 7;
  localparam int BIT_LOAD = 6;
  localparam int BIT_FLAG = 5;
  localparam int BIT_CLEAR = 4;
  localparam int INV_LSB = 0;
  // period_high field positions
  localparam int BIT_IRQ_EN = 7;
  localparam int PHIGH_W = 2;
  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;
  localparam logic [NUM_CH-1:0] INV_RESET = 4'h0;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/pcr_top.sv
/*
  pcr_top: pwm counter, deferred reload, underflow flag and channel
  inversion, programmed over an axi4-lite slave.
  assumes: one clock, synchronous active-low reset, master per axi4-lite.
*/
// Local design decision: the AXI4-Lite register port.
// Function
// [R1] with the reload bit at 0 the period and duty registers never reach counter or comparators.
// [R2] with the reload bit at 1 period and duties are copied at the next counter underflow.
// [R3] hardware clears the reload bit on the clock after the reload was done.
// [R4] the underflow flag sets when the 10-bit down counter underflows and stays 0 otherwise.
// [R5] while the flag is set the interrupt is requested if the interrupt is enabled.
// [R6] hardware never clears the flag; software clears it by writing the control register.
// [R7] bits 3 to 0 invert the outputs of channels 3 to 0 when set.
// [R8] the run bit starts the counter and generator at 1 and halts them at 0.
// [R9] writing 1 to the clear bit zeroes the counter and the bit then clears itself.
`timescale 1ns/10ps
`default_nettype none
module pcr_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pcr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pcr_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pcr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [pcr_pkg::NUM_CH-1:0] pwm_out,
  output logic pwm_irq
);
  localparam int N = pcr_pkg::NUM_CH;
  localparam int CW = pcr_pkg::CNT_W;

  // write channel state
  logic aw_have, w_have, aw_ok;
  logic [pcr_pkg::IDX_W-1:0] aw_idx;
  logic [7:0] wb;
  logic w_lane0;
  // control and data registers
  logic run, load, flag, clear_req, load_done, irq_en;
  logic [N-1:0] inv;
  logic [7:0] period_low, duty_high;
  logic [pcr_pkg::PHIGH_W-1:0] period_high;
  logic [7:0] duty_low [N];
  logic [CW-1:0] cnt, period_act;
  logic [CW-1:0] duty_act [N];

  // handshakes and decode
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire [pcr_pkg::IDX_W-1:0] awa_idx = s_axi_awaddr[9:2];
  logic [N-1:0] aw_duty_hit;
  // only mapped, aligned words are written; anything else answers slverr
  wire awa_map = (awa_idx == pcr_pkg::IDX_CONTROL_ONE) || (awa_idx == pcr_pkg::IDX_PERIOD_LOW) ||
    (awa_idx == pcr_pkg::IDX_PERIOD_HIGH) || (awa_idx == pcr_pkg::IDX_DUTY_HIGH) || (|aw_duty_hit);
  wire awa_ok = awa_map && (s_axi_awaddr[11:10] == 2'h0) && (s_axi_awaddr[1:0] == 2'h0);
  wire wr_en = do_write && aw_ok && w_lane0;
  wire wr_ctrl = wr_en && (aw_idx == pcr_pkg::IDX_CONTROL_ONE);
  wire wr_plow = wr_en && (aw_idx == pcr_pkg::IDX_PERIOD_LOW);
  wire wr_phigh = wr_en && (aw_idx == pcr_pkg::IDX_PERIOD_HIGH);
  wire wr_dhigh = wr_en && (aw_idx == pcr_pkg::IDX_DUTY_HIGH);
  wire [CW-1:0] period_reg = {period_high, period_low};
  // counter events; clear request outranks counting
  wire uf = run && !clear_req && (cnt == pcr_pkg::CNT_RESET);
  wire reload = uf && load;

  // read decode
  wire [pcr_pkg::IDX_W-1:0] ar_idx = s_axi_araddr[9:2];
  wire ar_ok = (s_axi_araddr[11:10] == 2'h0) && (s_axi_araddr[1:0] == 2'h0);
  wire [7:0] ctrl_rd = {run, load, flag, clear_req, inv};
  wire [7:0] phigh_rd = {irq_en, 5'h00, period_high};
  logic [N-1:0] duty_hit;
  logic [7:0] duty_rd [N];
  wire hit_ctrl = ar_idx == pcr_pkg::IDX_CONTROL_ONE;
  wire hit_plow = ar_idx == pcr_pkg::IDX_PERIOD_LOW;
  wire hit_phigh = ar_idx == pcr_pkg::IDX_PERIOD_HIGH;
  wire hit_dhigh = ar_idx == pcr_pkg::IDX_DUTY_HIGH;
  wire rd_hit = ar_ok && (hit_ctrl || hit_plow || hit_phigh || hit_dhigh || (|duty_hit));
  wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                       hit_plow ? period_low :
                       hit_phigh ? phigh_rd :
                       hit_dhigh ? duty_high :
                       duty_rd[N-1];

  // per-channel duty storage, read chain and output stage
  for (genvar i = 0; i < N; i++) begin : g_ch
    wire wr_dlow = wr_en && (aw_idx == pcr_pkg::IDX_DUTY_LOW[i]);
    wire [CW-1:0] duty_full = {duty_high[2*i+1:2*i], duty_low[i]};
    assign duty_hit[i] = ar_idx == pcr_pkg::IDX_DUTY_LOW[i];
    assign aw_duty_hit[i] = awa_idx == pcr_pkg::IDX_DUTY_LOW[i];
    if (i == 0) begin : g_first
      assign duty_rd[i] = duty_hit[i] ? duty_low[i] : pcr_pkg::BYTE_RESET;
    end else begin : g_next
      assign duty_rd[i] = duty_hit[i] ? duty_low[i] : duty_rd[i-1];
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        duty_low[i] <= pcr_pkg::BYTE_RESET;
        duty_act[i] <= pcr_pkg::CNT_RESET;
      end else begin
        if (wr_dlow) duty_low[i] <= wb;
        if (reload) duty_act[i] <= duty_full; // [R1] [R2]
      end
    end
    pcr_chan_out u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(run),
      .cnt(cnt),
      .duty(duty_act[i]),
      .invert(inv[i]),
      .pin(pwm_out[i])
    );
  end

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_ok <= 1'b0;
      aw_idx <= pcr_pkg::BYTE_RESET;
      wb <= pcr_pkg::BYTE_RESET;
      w_lane0 <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have && !aw_fire && !do_write;
      s_axi_wready <= !w_have && !w_fire && !do_write;
      if (aw_fire) begin
        aw_have <= 1'b1;
        aw_idx <= awa_idx;
        aw_ok <= awa_ok;
      end else if (do_write) begin
        aw_have <= 1'b0;
      end
      if (w_fire) begin
        w_have <= 1'b1;
        wb <= s_axi_wdata[7:0]; // only the low byte is stored anywhere
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_have <= 1'b0;
      end
    end
  end

  // write response; unmapped or misaligned answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pcr_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_ok ? pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pcr_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_hit ? rd_byte : pcr_pkg::BYTE_RESET};
      s_axi_rresp <= rd_hit ? pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // plain software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_low <= pcr_pkg::BYTE_RESET;
      period_high <= '0;
      irq_en <= 1'b0;
      duty_high <= pcr_pkg::BYTE_RESET;
      run <= 1'b0;
      inv <= pcr_pkg::INV_RESET;
    end else begin
      if (wr_plow) period_low <= wb;
      if (wr_phigh) period_high <= wb[pcr_pkg::PHIGH_W-1:0];
      if (wr_phigh) irq_en <= wb[pcr_pkg::BIT_IRQ_EN];
      if (wr_dhigh) duty_high <= wb;
      if (wr_ctrl) run <= wb[pcr_pkg::BIT_RUN]; // [R8]
      if (wr_ctrl) inv <= wb[pcr_pkg::INV_LSB +: N]; // [R7]
    end
  end

  // control bits that hardware also changes; a set wins, whether from software or from an underflow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load <= 1'b0;
      load_done <= 1'b0;
      flag <= 1'b0;
      clear_req <= 1'b0;
      pwm_irq <= 1'b0;
    end else begin
      load_done <= reload;
      if (wr_ctrl) load <= wb[pcr_pkg::BIT_LOAD];
      else if (load_done) load <= 1'b0; // [R3]
      if (uf) flag <= 1'b1; // [R4]
      else if (wr_ctrl && !wb[pcr_pkg::BIT_FLAG]) flag <= 1'b0; // [R6]
      clear_req <= wr_ctrl && wb[pcr_pkg::BIT_CLEAR]; // [R9]
      pwm_irq <= flag && irq_en; // [R5]
    end
  end

  // down counter; a halted counter keeps its value except on a clear request, which zeroes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= pcr_pkg::CNT_RESET;
      period_act <= pcr_pkg::CNT_RESET;
    end else begin
      if (clear_req) cnt <= pcr_pkg::CNT_RESET; // [R9]
      else if (reload) cnt <= period_reg; // [R2]
      else if (uf) cnt <= period_act; // [R1]
      else if (run) cnt <= cnt - 10'h001; // [R8]
      if (reload) period_act <= period_reg; // [R2]
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_no_reload_idle: assert property (!load |=> $stable(period_act)) // [R1]
    else $error("active period changed without reload request");
  chk_reload_at_uf: assert property (reload |=> // [R2]
    (period_act == $past(period_reg)) && (cnt == $past(period_reg)))
    else $error("reload did not copy period at underflow");
  chk_load_autoclear: assert property (reload ##1 !wr_ctrl |=> !load) // [R3]
    else $error("reload bit not cleared after reload");
  chk_flag_sets: assert property (uf |=> flag) // [R4]
    else $error("underflow did not set flag");
  chk_flag_quiet: assert property (!flag && !uf |=> !flag) // [R4]
    else $error("flag set without underflow");
  chk_irq_gate: assert property (##1 (pwm_irq == $past(flag && irq_en))) // [R5]
    else $error("interrupt request does not follow flag and enable");
  chk_flag_sticky: assert property (flag && !wr_ctrl |=> flag) // [R6]
    else $error("flag cleared without software write");
  chk_run_halts: assert property (!run && !clear_req |=> $stable(cnt)) // [R8]
    else $error("counter moved while halted");
  chk_clear_zero: assert property (wr_ctrl && wb[pcr_pkg::BIT_CLEAR] |=> // [R9]
    clear_req ##1 (cnt == pcr_pkg::CNT_RESET && !clear_req))
    else $error("clear bit did not zero counter and self clear");

  cov_reload: cover property (reload ##2 !load);
  cov_flag_clear: cover property (flag ##1 !flag);
  cov_irq: cover property (pwm_irq);
  cov_counter_clear: cover property (clear_req && run);
endmodule // pcr_top
`default_nettype wire

// >>> sim/pcr_pin_load.sv
/*
  pcr_pin_load: load on the four pwm pins, counting high cycles per window.
  assumes: pins sampled at rising aclk, start is a one-cycle pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module pcr_pin_load #(
  parameter int WIN = 100
) (
  input wire logic aclk,
  input wire logic start,
  input wire logic [pcr_pkg::NUM_CH-1:0] pins,
  output logic [pcr_pkg::NUM_CH-1:0][7:0] high_cnt,
  output logic done
);
  int left = 0;

  initial begin
    done = 1'b0;
    high_cnt = '0;
  end

  // pure sink: it never drives back, so a window is exactly WIN samples
  always @(posedge aclk) begin
    done <= 1'b0;
    if (start) begin
      high_cnt <= '0;
      left <= WIN;
    end else if (left > 0) begin
      for (int i = 0; i < pcr_pkg::NUM_CH; i++) high_cnt[i] <= high_cnt[i] + 8'(pins[i]);
      left <= left - 1;
      done <= (left == 1);
    end
  end
endmodule // pcr_pin_load
`default_nettype wire

// >>> sim/pcr_top_bench.sv
/*
  pcr_top_bench: self-checking bench for pcr_top over axi4-lite.
  assumes: pcr_pin_load measures the channel outputs in 100-cycle windows.
*/
`timescale 1ns/10ps
`default_nettype none
module pcr_top_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pwm_irq, done;
  logic start = 1'b0;
  logic [1:0] bresp, rresp;
  logic [3:0] pwm_out;
  logic [3:0][7:0] hi;
  logic [31:0] rnd = 32'h3bd8;
  logic [33:0] exp_r [$];
  logic [1:0] exp_b [$];
  logic [32:0] exp_c [$];
  int n_errors = 0;
  int n_tests = 0;

  // 40 mhz
  always #12.5 aclk = ~aclk;

  pcr_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pwm_out(pwm_out), .pwm_irq(pwm_irq));
  pcr_pin_load #(.WIN(100)) u_load (.aclk(aclk), .start(start), .pins(pwm_out),
    .high_cnt(hi), .done(done));

  task automatic summarize();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic note(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    n_errors++;
    $display("BAD %s expected answer seen timeout", nm);
    summarize();
  endtask

  task automatic cmp_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
    note(nm, e, g);
  endtask

  task automatic cmp_irq(input logic e);
    note("pwm_irq", 34'(e), 34'(pwm_irq));
  endtask

  // steady windows only ask that each pin stayed at one level throughout
  task automatic cmp_cnt(input logic [32:0] e);
    logic [3:0] st;
    for (int i = 0; i < 4; i++) st[i] = (hi[i] == 8'h00) || (hi[i] == 8'h64);
    note("counts", 34'(e[31:0]), e[32] ? 34'(st) : 34'(hi));
  endtask

  // oldest note against each answer as it appears
  always @(posedge aclk) begin
    if (bvalid && bready) cmp_bus("bresp", 34'(exp_b.pop_front()), 34'(bresp));
    if (rvalid && rready) cmp_bus("read", exp_r.pop_front(), {rresp, rdata});
    if (done) cmp_cnt(exp_c.pop_front());
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // high cycles per window: duty times (period + 1) = 10, flipped where inverted
  function automatic logic [32:0] pat(input logic [3:0] inv);
    logic [7:0] d [4];
    d = '{8'h1e, 8'h46, 8'h00, 8'h64};
    for (int i = 0; i < 4; i++) pat[8*i +: 8] = inv[i] ? 8'h64 - d[i] : d[i];
    pat[32] = 1'b0;
  endfunction

  // both write channels offered at once, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    int k;
    logic got;
    k = 0;
    got = 1'b0;
    exp_b.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got && k < 100) begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        got = 1'b1;
      end
    end
    if (!got) hang("bvalid");
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    int k;
    logic got;
    k = 0;
    got = 1'b0;
    exp_r.push_back({e, 24'h0, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && k < 100) begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        got = 1'b1;
      end
    end
    if (!got) hang("rvalid");
  endtask

  task automatic meas(input logic [32:0] e);
    int k;
    k = 0;
    exp_c.push_back(e);
    @(posedge aclk);
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    while (!done && k < 200) begin
      @(posedge aclk);
      k++;
    end
    if (!done) hang("window");
  endtask

  // main sequence; duties 3, 7, 0, 10 over period 9
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h370, 8'h00, pcr_pkg::RESP_OKAY);
    rd(12'h368, 8'h00, pcr_pkg::RESP_OKAY);
    rd(12'h3a0, 8'h00, pcr_pkg::RESP_OKAY);
    rd(12'h369, 8'h00, pcr_pkg::RESP_SLVERR);
    rd(12'h000, 8'h00, pcr_pkg::RESP_SLVERR);
    wr(12'h004, 8'h55, pcr_pkg::RESP_SLVERR);
    wr(12'h364, 8'h09, pcr_pkg::RESP_OKAY);
    wr(12'h368, 8'h03, pcr_pkg::RESP_OKAY);
    wr(12'h36c, 8'h07, pcr_pkg::RESP_OKAY);
    wr(12'h374, 8'h00, pcr_pkg::RESP_OKAY);
    wr(12'h378, 8'h0a, pcr_pkg::RESP_OKAY);
    rd(12'h36c, 8'h07, pcr_pkg::RESP_OKAY);
    wr(12'h370, 8'h80, pcr_pkg::RESP_OKAY);
    meas(33'h0);
    rd(12'h370, 8'ha0, pcr_pkg::RESP_OKAY);
    // period 0 underflows every clock, so the halting write meets an underflow and the flag stays
    wr(12'h370, 8'h00, pcr_pkg::RESP_OKAY);
    rd(12'h370, 8'h20, pcr_pkg::RESP_OKAY);
    wr(12'h370, 8'h00, pcr_pkg::RESP_OKAY);
    rd(12'h370, 8'h00, pcr_pkg::RESP_OKAY);
    repeat (30) @(posedge aclk);
    rd(12'h370, 8'h00, pcr_pkg::RESP_OKAY);
    wr(12'h370, 8'hc0, pcr_pkg::RESP_OKAY);
    rd(12'h370, 8'ha0, pcr_pkg::RESP_OKAY);
    meas(pat(4'h0));
    wr(12'h368, 8'h08, pcr_pkg::RESP_OKAY);
    meas(pat(4'h0));
    repeat (3) begin
      rnd = lfsr(rnd);
      wr(12'h370, {4'ha, rnd[3:0]}, pcr_pkg::RESP_OKAY);
      rd(12'h370, {4'ha, rnd[3:0]}, pcr_pkg::RESP_OKAY);
      meas(pat(rnd[3:0]));
    end
    wr(12'h3a4, 8'h80, pcr_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    cmp_irq(1'b1);
    wr(12'h370, 8'h20, pcr_pkg::RESP_OKAY);
    meas({1'b1, 32'hf});
    rd(12'h370, 8'h20, pcr_pkg::RESP_OKAY);
    wr(12'h370, 8'h00, pcr_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    cmp_irq(1'b0);
    wr(12'h3a4, 8'h00, pcr_pkg::RESP_OKAY);
    wr(12'h370, 8'h80, pcr_pkg::RESP_OKAY);
    repeat (12) @(posedge aclk);
    cmp_irq(1'b0);
    rd(12'h370, 8'ha0, pcr_pkg::RESP_OKAY);
    // flag bit written as 1 so an underflow in the halting cycle cannot change the answer
    wr(12'h370, 8'h30, pcr_pkg::RESP_OKAY);
    rd(12'h370, 8'h20, pcr_pkg::RESP_OKAY);
    summarize();
  end
endmodule // pcr_top_bench
`default_nettype wire
